// ===== logic/rtsa_byte_store.sv
// Byte map storage: one write port, asynchronous read port
`timescale 1ns/1ps
module rtsa_byte_store #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clock_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [DEPTH];

    // Contents survive reset, as battery-backed storage would
    always_ff @(posedge clock_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = mem[addr_in];
endmodule

// ===== logic/rtsa_line_filter.sv
// Two-stage synchroniser and glitch filter for the incoming lines
`timescale 1ns/1ps
module rtsa_line_filter #(
    parameter int WIDTH = 4,
    parameter int SAMPLES = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] line_in,
    output logic [WIDTH-1:0] line_out
);
    genvar gi;
    // One filter per line; output moves only once SAMPLES agree
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_line
            logic s1_q;
            logic s2_q;
            logic [SAMPLES-1:0] hist_q;
            logic out_q;
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    s1_q <= RST_VAL[gi];
                    s2_q <= RST_VAL[gi];
                    hist_q <= {SAMPLES{RST_VAL[gi]}};
                    out_q <= RST_VAL[gi];
                end else begin
                    s1_q <= line_in[gi];
                    s2_q <= s1_q;
                    hist_q <= {hist_q[SAMPLES-2:0], s2_q};
                    if (&hist_q) begin
                        out_q <= 1'b1;
                    end else if (~|hist_q) begin
                        out_q <= 1'b0;
                    end
                end
            end
            assign line_out[gi] = out_q;
        end
    endgenerate
endmodule

// ===== logic/rtsa_pkg.sv
// Shared constants and types for the clock-chip two-wire slave access block
package rtsa_pkg;
    // Bus address, 7 bits; D0h on the wire once the direction bit is appended
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    // Byte map layout
    localparam int MAP_BYTES = 64;
    localparam int PTR_W = 6;
    localparam logic [5:0] IDX_RSVD_FIRST = 6'h10;
    localparam logic [5:0] IDX_RSVD_LAST = 6'h12;
    localparam logic [5:0] IDX_SQW = 6'h13;
    localparam logic [5:0] IDX_RAM_FIRST = 6'h14;
    localparam logic [5:0] PTR_RST = 6'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // Line levels and reset values
    localparam logic SDA_DRIVE_LVL = 1'b0;
    localparam logic [3:0] LINE_RST = 4'h3;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    // Timing
    localparam int CLK_HZ = 50000000;
    localparam int CLK_NS = 20;
    localparam int GLITCH_NS = 30;
    localparam int GLITCH_SAMPLES = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] CYCLES_PER_MS_DEF = 16'(CLK_HZ / 1000);
    localparam int MS_W = 8;
    localparam logic [7:0] REC_MIN_MS = 8'h28;
    localparam logic [7:0] REC_MAX_MS = 8'hC8;
    // Supply states and bus phases
    typedef enum logic [1:0] {PWR_NORMAL, PWR_DESELECT, PWR_BATTERY, PWR_RECOVER} rtsa_pwr_e;
    typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_TXACK} rtsa_bus_e;
endpackage

// ===== logic/rtsa_slave.sv
// Two-wire slave access to the 64-byte clock map, with supply-fail handling
`timescale 1ns/1ps
module rtsa_slave #(
    parameter logic [15:0] CYCLES_PER_MS = rtsa_pkg::CYCLES_PER_MS_DEF
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic deselect_in,
    input wire logic switchover_in,
    input wire logic [rtsa_pkg::MS_W-1:0] powerup_ms_in,
    output logic write_protect_out,
    output logic retention_out,
    output logic busy_out
);
    import rtsa_pkg::*;

    logic [3:0] filt;
    logic scl_f;
    logic sda_f;
    logic des_s;
    logic sw_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic block;
    rtsa_bus_e st_q;
    rtsa_pwr_e pwr_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic first_q;
    logic word_q;
    logic rw_q;
    logic nack_q;
    logic sda_oe_q;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0] mem_rd;
    logic [7:0] rd_byte;
    logic rsvd;
    logic mem_we;
    logic ack_clk;
    logic ptr_evt;
    logic [15:0] div_q;
    logic [MS_W-1:0] ms_q;
    logic [MS_W-1:0] rec_tgt;
    logic rec_done;
    logic rec_exit;
    logic wp_q;
    logic ret_q;
    logic busy_q;
    logic sda_lvl_q;

    // Lines idle high, supply flags idle low
    rtsa_line_filter #(
        .WIDTH(4),
        .SAMPLES(GLITCH_SAMPLES),
        .RST_VAL(LINE_RST)
    ) u_filter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .line_in({switchover_in, deselect_in, sda_in, scl_in}),
        .line_out(filt)
    );

    assign scl_f = filt[0];
    assign sda_f = filt[1];
    assign des_s = filt[2];
    assign sw_s = filt[3];

    // Previous filtered levels for edge finding
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // Edges and bus conditions; a data change under clock high is control
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_evt = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_evt = scl_f & scl_p_q & ~sda_p_q & sda_f;
    // Supply trouble or recovery in progress shuts the bus out
    assign block = des_s | sw_s | (pwr_q != PWR_NORMAL);

    // Reserved bytes read as zero and refuse writes
    assign rsvd = (ptr_q >= IDX_RSVD_FIRST) && (ptr_q <= IDX_RSVD_LAST);
    assign rd_byte = rsvd ? RSVD_READ : mem_rd;
    assign ack_clk = ~block & scl_rise & (st_q == BUS_ACK) & ~first_q;
    assign mem_we = ack_clk & ~word_q & ~rsvd;
    assign ptr_evt = ack_clk | (~block & scl_rise & (st_q == BUS_TXACK) & ~sda_f) | des_s | sw_s;

    rtsa_byte_store #(
        .DEPTH(MAP_BYTES),
        .AW(PTR_W)
    ) u_store (
        .clock_in(clock_in),
        .we_in(mem_we),
        .addr_in(ptr_q),
        .wdata_in(sh_q),
        .rdata_out(mem_rd)
    );

    // Bus phase machine; supply trouble forces it idle and releases the line
    always_ff @(posedge clock_in) begin
        if (rst_in || block) begin
            st_q <= BUS_IDLE;
            bit_q <= 4'h0;
            sh_q <= BYTE_RST;
            first_q <= 1'b0;
            word_q <= 1'b0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_evt) begin
            st_q <= BUS_RX;
            bit_q <= 4'h0;
            first_q <= 1'b1;
            word_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_evt) begin
            st_q <= BUS_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                BUS_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_f};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
                        if (first_q && sh_q[7:1] != SLAVE_ADDR) begin
                            st_q <= BUS_IDLE;
                        end else begin
                            st_q <= BUS_ACK;
                            sda_oe_q <= 1'b1;
                            rw_q <= first_q ? sh_q[0] : rw_q;
                        end
                    end
                end
                BUS_ACK: begin
                    // Low held from the fall before the ack pulse to the fall after it
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        first_q <= 1'b0;
                        word_q <= first_q;
                        if (first_q && rw_q) begin
                            st_q <= BUS_TX;
                            sh_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                        end else begin
                            st_q <= BUS_RX;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                BUS_TX: begin
                    // New bit only after the clock falls
                    if (scl_fall) begin
                        if (bit_q == TX_LAST_BIT) begin
                            st_q <= BUS_TXACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6];
                        end
                    end
                end
                BUS_TXACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_f;
                    end else if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (nack_q) begin
                            st_q <= BUS_IDLE;
                        end else begin
                            st_q <= BUS_TX;
                            sh_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    st_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // Byte pointer: word byte loads it, ack clocks advance it, wraps at 64
    always_ff @(posedge clock_in) begin
        if (rst_in || des_s || sw_s) begin
            ptr_q <= PTR_RST;
        end else if (ack_clk) begin
            ptr_q <= word_q ? sh_q[PTR_W-1:0] : ptr_q + 6'h01;
        end else if (!block && scl_rise && st_q == BUS_TXACK && !sda_f) begin
            ptr_q <= ptr_q + 6'h01;
        end
    end

    // Supply state: deselect, battery retention, timed recovery
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pwr_q <= PWR_NORMAL;
        end else begin
            case (pwr_q)
                PWR_NORMAL: begin
                    if (sw_s) begin
                        pwr_q <= PWR_BATTERY;
                    end else if (des_s) begin
                        pwr_q <= PWR_DESELECT;
                    end
                end
                PWR_DESELECT: begin
                    if (sw_s) begin
                        pwr_q <= PWR_BATTERY;
                    end else if (!des_s) begin
                        pwr_q <= PWR_RECOVER;
                    end
                end
                PWR_BATTERY: begin
                    if (!sw_s) begin
                        pwr_q <= des_s ? PWR_DESELECT : PWR_RECOVER;
                    end
                end
                PWR_RECOVER: begin
                    if (sw_s) begin
                        pwr_q <= PWR_BATTERY;
                    end else if (des_s) begin
                        pwr_q <= PWR_DESELECT;
                    end else if (rec_done) begin
                        pwr_q <= PWR_NORMAL;
                    end
                end
                default: begin
                    pwr_q <= PWR_DESELECT;
                end
            endcase
        end
    end

    // Interval clamped to its legal range so a bad setting cannot skip it
    assign rec_tgt = (powerup_ms_in < REC_MIN_MS) ? REC_MIN_MS :
                     (powerup_ms_in > REC_MAX_MS) ? REC_MAX_MS : powerup_ms_in;
    assign rec_done = (ms_q >= rec_tgt);
    assign rec_exit = (pwr_q == PWR_RECOVER) && rec_done;

    // Millisecond counter runs only while recovering
    always_ff @(posedge clock_in) begin
        if (rst_in || pwr_q != PWR_RECOVER) begin
            div_q <= 16'h0000;
            ms_q <= 8'h00;
        end else if (div_q == CYCLES_PER_MS - 16'h0001) begin
            div_q <= 16'h0000;
            ms_q <= ms_q + 8'h01;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // Registered status; the line level is constant since the pin is open drain
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wp_q <= 1'b0;
            ret_q <= 1'b0;
            busy_q <= 1'b0;
            sda_lvl_q <= SDA_DRIVE_LVL;
        end else begin
            wp_q <= block;
            ret_q <= (pwr_q == PWR_BATTERY);
            busy_q <= (st_q != BUS_IDLE);
            sda_lvl_q <= SDA_DRIVE_LVL;
        end
    end

    assign sda_out = sda_lvl_q;
    assign sda_oe_out = sda_oe_q;
    assign write_protect_out = wp_q;
    assign retention_out = ret_q;
    assign busy_out = busy_q;

    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    AST_ADDR_MISMATCH: assert property (
        (!block && st_q == BUS_RX && first_q && scl_fall && bit_q == BITS_PER_BYTE
         && sh_q[7:1] != SLAVE_ADDR) |=> (st_q == BUS_IDLE && !sda_oe_q))
        else $error("wrong address was not ignored");
    AST_ADDR_ACK: assert property (
        (!block && st_q == BUS_RX && scl_fall && bit_q == BITS_PER_BYTE
         && (!first_q || sh_q[7:1] == SLAVE_ADDR)) |=> (st_q == BUS_ACK && sda_oe_q))
        else $error("received byte not acknowledged");
    AST_ACK_LOW: assert property (
        (st_q == BUS_ACK) |-> sda_oe_q)
        else $error("data line not held low during acknowledge");
    AST_ABORT: assert property (
        $rose(des_s) |=> (st_q == BUS_IDLE && ptr_q == PTR_RST && !sda_oe_q))
        else $error("transfer not aborted on supply fail");
    AST_NO_WRITE: assert property (
        mem_we |-> (pwr_q == PWR_NORMAL && !des_s && !sw_s))
        else $error("write while protected");
    AST_RETAIN: assert property (
        sw_s [*2] |=> retention_out)
        else $error("retention not entered below switchover");
    AST_PROTECT_HOLD: assert property (
        $fell(write_protect_out) |-> $past(rec_exit, 2))
        else $error("protection released before recovery interval");
    AST_REC_RANGE: assert property (
        (rec_tgt >= REC_MIN_MS) && (rec_tgt <= REC_MAX_MS))
        else $error("recovery interval out of range");
    AST_START: assert property (
        (start_evt && !block) |=> (st_q == BUS_RX && bit_q == 4'h0 && first_q))
        else $error("start not recognised");
    AST_STOP: assert property (
        (stop_evt && !block) |=> (st_q == BUS_IDLE && !sda_oe_q))
        else $error("stop not recognised");
    AST_TX_STABLE: assert property (
        (scl_f && scl_p_q && st_q == BUS_TX && $past(st_q) == BUS_TX) |-> $stable(sda_oe_q))
        else $error("data changed while clock high");
    AST_TXACK_FREE: assert property (
        (st_q == BUS_TXACK) |-> !sda_oe_q)
        else $error("line not released for master acknowledge");
    AST_PTR_ADV: assert property (
        $changed(ptr_q) |-> $past(ptr_evt))
        else $error("pointer moved without acknowledge clock");

    COV_WRITE: cover property (mem_we);
    COV_READ_NACK: cover property (st_q == BUS_TXACK && scl_fall && nack_q);
    COV_ABORT: cover property (st_q == BUS_RX ##1 des_s);
    COV_RECOVER: cover property (rec_exit ##1 pwr_q == PWR_NORMAL);
endmodule

// ===== tb/rtsa_master_model.sv
// Behavioural two-wire bus master that drives the slave's clock and data lines
`timescale 1ns/1ps
module rtsa_master_model (
    input wire logic clock_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_drv_out
);
    // Both lines released while the bus rests; the clock stands still between frames
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // Long phases so a late ack release by the slave clears before the clock rises
    task automatic start_cond();
        sda_drv_out <= 1'b1;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_drv_out <= 1'b0;
        tick(8);
        scl_out <= 1'b0;
        tick(4);
    endtask

    // One 240 ns bit: an eight-clock low phase outlasts the slave's answer delay,
    // so its data change lands before the clock rises
    task automatic put_bit(input logic b, output logic r);
        tick(2);
        sda_drv_out <= b;
        tick(6);
        scl_out <= 1'b1;
        tick(3);
        @(negedge clock_in);
        r = sda_in;
        tick(1);
        scl_out <= 1'b0;
    endtask

    // Byte out, MSB first, then the ninth clock for the slave's ack
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; the master withholds the ack on the final byte
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(~ack, r);
    endtask

    // One-clock dip on the data line while the clock rests high; no start
    task automatic glitch();
        sda_drv_out <= 1'b0;
        tick(1);
        sda_drv_out <= 1'b1;
        tick(12);
    endtask

    // Bus stays free well past the minimum before the next frame
    task automatic stop_cond();
        tick(2);
        sda_drv_out <= 1'b0;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_drv_out <= 1'b1;
        tick(70);
    endtask
endmodule

// ===== tb/rtsa_slave_tb.sv
// Self-checking bench for the two-wire slave access block
`timescale 1ns/1ps
module rtsa_slave_tb;
    logic clock_in = 1'b0;
    logic rst_in;
    logic deselect;
    logic switchover;
    logic [7:0] powerup_ms;
    logic scl;
    logic m_sda;
    logic sda_w;
    logic sda_out;
    logic sda_oe;
    logic wp;
    logic ret;
    logic busy;
    int fails = 0;
    int compares = 0;

    // 50 MHz system clock
    always #10 clock_in = ~clock_in;

    // Open-drain wire with pull-up: low if either party pulls
    assign sda_w = m_sda & (sda_oe ? sda_out : 1'b1);

    rtsa_master_model m (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_drv_out(m_sda));

    // Short millisecond so the 40..200 ms recovery fits the run
    rtsa_slave #(.CYCLES_PER_MS(16'h0004)) dut (
        .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .deselect_in(deselect),
        .switchover_in(switchover), .powerup_ms_in(powerup_ms),
        .write_protect_out(wp), .retention_out(ret), .busy_out(busy)
    );

    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bounded wait on a supply flag, sampled away from the active edge
    task automatic wait_out(input logic sel, input logic val, input int lim);
        int n;
        n = 0;
        while ((sel ? ret : wp) !== val && n < lim) begin
            @(negedge clock_in);
            n++;
        end
        check(sel ? "retention" : "write protect", {7'h00, sel ? ret : wp}, {7'h00, val});
        if ((sel ? ret : wp) !== val) begin
            results();
        end
        @(posedge clock_in);
    endtask

    task automatic write_seq(input logic [7:0] a, input logic [7:0] d [5], input int n);
        logic k;
        m.start_cond();
        m.send_byte(8'hD0, k);
        check("address ack", {7'h00, k}, 8'h01);
        m.send_byte(a, k);
        check("word ack", {7'h00, k}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m.send_byte(d[i], k);
            check("data ack", {7'h00, k}, 8'h01);
        end
        m.stop_cond();
        check("busy after stop", {7'h00, busy}, 8'h00);
    endtask

    // Sets the pointer, then a repeated start turns the bus round for reading
    task automatic read_seq(input logic [7:0] a, input logic [7:0] e [5], input int n);
        logic k;
        logic [7:0] v;
        m.start_cond();
        m.send_byte(8'hD0, k);
        m.send_byte(a, k);
        m.start_cond();
        m.send_byte(8'hD1, k);
        check("read address ack", {7'h00, k}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m.get_byte(i < n - 1, v);
            check("read data", v, e[i]);
        end
        check("line released", {7'h00, sda_oe}, 8'h00);
        m.stop_cond();
    endtask

    // Write across the top of the map; pointer wraps to byte 00h
    task automatic sc_write_read();
        write_seq(8'h3E, '{8'hA5, 8'h5A, 8'hC3, 8'h00, 8'h00}, 3);
        read_seq(8'h3E, '{8'hA5, 8'h5A, 8'hC3, 8'h00, 8'h00}, 3);
    endtask

    // Reserved bytes ignore writes, square-wave and RAM bytes keep theirs
    task automatic sc_map();
        write_seq(8'h10, '{8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h66}, 5);
        read_seq(8'h10, '{8'h00, 8'h00, 8'h00, 8'h77, 8'h66}, 5);
    endtask

    // A one-clock glitch is no start; a foreign address gets no ack
    task automatic sc_foreign();
        logic k;
        m.glitch();
        check("busy after glitch", {7'h00, busy}, 8'h00);
        m.start_cond();
        check("busy after start", {7'h00, busy}, 8'h01);
        m.send_byte(8'hA0, k);
        check("foreign address ack", {7'h00, k}, 8'h00);
        m.stop_cond();
    endtask

    // Supply fails mid byte; bus ignored, then locked through recovery
    task automatic sc_deselect(input logic [7:0] ms);
        logic k;
        logic [7:0] v;
        powerup_ms <= ms;
        write_seq(8'h20, '{8'h11, 8'h33, 8'h00, 8'h00, 8'h00}, 2);
        m.start_cond();
        m.send_byte(8'hD0, k);
        m.send_byte(8'h21, k);
        for (int i = 7; i >= 4; i--) begin
            m.put_bit(1'b0, k);
        end
        deselect <= 1'b1;
        wait_out(1'b0, 1'b1, 20);
        // Busy drops one clock after protection rises
        @(negedge clock_in);
        check("busy aborted", {7'h00, busy}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            m.put_bit(1'b1, k);
        end
        m.put_bit(1'b1, k);
        check("ack while deselected", {7'h00, ~k}, 8'h00);
        m.stop_cond();
        deselect <= 1'b0;
        m.tick(20);
        m.start_cond();
        m.send_byte(8'hD0, k);
        check("ack in recovery", {7'h00, k}, 8'h00);
        m.tick(2); // About ten clocks before the shortest interval ends
        check("still protected", {7'h00, wp}, 8'h01);
        wait_out(1'b0, 1'b0, 40);
        m.stop_cond();
        m.start_cond();
        m.send_byte(8'hD1, k);
        m.get_byte(1'b0, v);
        check("pointer cleared", v, 8'hC3);
        m.stop_cond();
        read_seq(8'h20, '{8'h11, 8'h33, 8'h00, 8'h00, 8'h00}, 2);
    endtask

    // Battery retention entered and left; longest clamped recovery
    task automatic sc_switchover(input logic [7:0] ms);
        powerup_ms <= ms;
        deselect <= 1'b1;
        switchover <= 1'b1;
        wait_out(1'b1, 1'b1, 20);
        m.tick(20);
        switchover <= 1'b0;
        wait_out(1'b1, 1'b0, 20);
        check("protected on return", {7'h00, wp}, 8'h01);
        deselect <= 1'b0;
        m.tick(790);
        check("long recovery", {7'h00, wp}, 8'h01);
        wait_out(1'b0, 1'b0, 40);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        rst_in = 1'b1;
        deselect = 1'b0;
        switchover = 1'b0;
        powerup_ms = 8'h28;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        sc_write_read();
        sc_map();
        sc_foreign();
        sc_deselect(8'h00);
        sc_switchover(8'hFF);
        results();
    end
endmodule
